// file: core/hdlc_defines.svh
/*
  register offsets and reset values of the drive level and calibration
  register group.
  assumes: included by the register bank module and by the bench.
*/
`ifndef HDLC_DEFINES_SVH
`define HDLC_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define HDLC_OFS_CEILING   8'h15
`define HDLC_OFS_FULL_REF  8'h16
`define HDLC_OFS_OD_LIMIT  8'h17
`define HDLC_OFS_LOSS_COMP 8'h18
`define HDLC_OFS_BEMF      8'h19

// ****************************************************************
// reset values
// ****************************************************************
`define HDLC_RST_CEILING   8'hff
`define HDLC_RST_FULL_REF  8'h3f
`define HDLC_RST_OD_LIMIT  8'h89
`define HDLC_RST_LOSS_COMP 8'h0d
`define HDLC_RST_BEMF      8'h6d

// ****************************************************************
// scaling constants
// ****************************************************************
`define HDLC_FULL_SCALE    8'hff

`endif

// file: core/hdlc_pkg.sv
/*
  types shared by the drive level and calibration register group.
  assumes: nothing beyond the defines header.
*/
package hdlc_pkg;

  // ****************************************************************
  // drive modes
  // ****************************************************************
  typedef enum logic [1:0] {
    HDLC_MODE_CLOSED = 2'b00,
    HDLC_MODE_OPEN   = 2'b01,
    HDLC_MODE_AUDIO  = 2'b10
  } hdlc_mode_e;

  // ****************************************************************
  // register state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ceiling_r;
    logic [7:0] full_ref_r;
    logic [7:0] od_limit_r;
    logic [7:0] loss_comp_r;
    logic [7:0] bemf_r;
    logic [7:0] rdata_r;
  } hdlc_state_s;

endpackage

// file: core/hdlc_regs.sv
/*
  drive level and calibration register group of a haptic driver: five
  host registers, reference selection and output limiting.
  assumes: the serial bus front end hands over decoded single-byte
  accesses synchronous to sys_clk; the calibration engine pulses a
  done strobe with its two results.
*/
`timescale 1ns/1ns

`include "hdlc_defines.svh"

module hdlc_regs
  import hdlc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // host register access
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  // calibration results
  input  wire logic        cal_done,
  input  wire logic [7:0]  cal_loss_comp,
  input  wire logic [7:0]  cal_bemf,
  // playback engine
  input  wire logic [1:0]  drive_mode,
  input  wire logic        overdrive_active,
  input  wire logic [7:0]  drive_request,
  input  wire logic [1:0]  back_emf_gain_select,
  output logic      [7:0]  drive_level,
  output logic      [7:0]  full_scale_ref,
  output logic      [15:0] drive_gain,
  output logic      [15:0] feedback_gain
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // scale a level by code/255, rounding down
  function automatic logic [7:0] scale255(input logic [7:0] lvl,
                                          input logic [7:0] code);
    logic [15:0] prod;
    prod = 16'(lvl) * 16'(code);
    scale255 = 8'(prod / 16'(`HDLC_FULL_SCALE));
  endfunction

  function automatic logic [7:0] min8(input logic [7:0] a,
                                      input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  hdlc_state_s st_r;
  hdlc_state_s st_nxt;
  hdlc_mode_e  mode;

  assign mode = hdlc_mode_e'(drive_mode);

  // ****************************************************************
  // register file
  // ****************************************************************
  // host write, calibration store and read data
  always_comb begin
    st_nxt = st_r;
    if (reg_wr) begin
      unique case (reg_addr)
        `HDLC_OFS_CEILING:   st_nxt.ceiling_r   = reg_wdata;
        `HDLC_OFS_FULL_REF:  st_nxt.full_ref_r  = reg_wdata;
        `HDLC_OFS_OD_LIMIT:  st_nxt.od_limit_r  = reg_wdata;
        `HDLC_OFS_LOSS_COMP: st_nxt.loss_comp_r = reg_wdata;
        `HDLC_OFS_BEMF:      st_nxt.bemf_r      = reg_wdata;
        default: ;
      endcase
    end
    // calibration result wins over a host write in the same cycle
    if (cal_done) begin
      st_nxt.loss_comp_r = cal_loss_comp;
      st_nxt.bemf_r      = cal_bemf;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `HDLC_OFS_CEILING:   st_nxt.rdata_r = st_r.ceiling_r;
        `HDLC_OFS_FULL_REF:  st_nxt.rdata_r = st_r.full_ref_r;
        `HDLC_OFS_OD_LIMIT:  st_nxt.rdata_r = st_r.od_limit_r;
        `HDLC_OFS_LOSS_COMP: st_nxt.rdata_r = st_r.loss_comp_r;
        `HDLC_OFS_BEMF:      st_nxt.rdata_r = st_r.bemf_r;
        default:             st_nxt.rdata_r = 8'h00;
      endcase
    end
  end

  // state register with reset values
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r.ceiling_r   <= `HDLC_RST_CEILING;
      st_r.full_ref_r  <= `HDLC_RST_FULL_REF;
      st_r.od_limit_r  <= `HDLC_RST_OD_LIMIT;
      st_r.loss_comp_r <= `HDLC_RST_LOSS_COMP;
      st_r.bemf_r      <= `HDLC_RST_BEMF;
      st_r.rdata_r     <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata_r;
  assign reg_hit   = (reg_addr >= `HDLC_OFS_CEILING) &&
                     (reg_addr <= `HDLC_OFS_BEMF);

  // ****************************************************************
  // reference selection and drive limiting
  // ****************************************************************
  logic [7:0] ref_sel;
  logic [7:0] lvl_sel;

  // full-scale reference per mode and the level sent to the drive
  always_comb begin
    ref_sel = st_r.full_ref_r;
    lvl_sel = 8'h00;
    unique case (mode)
      HDLC_MODE_CLOSED: begin
        ref_sel = st_r.full_ref_r;
        // overdrive may pass the rating, up to the limit
        if (overdrive_active)
          lvl_sel = min8(drive_request, st_r.od_limit_r);
        else
          lvl_sel = scale255(st_r.full_ref_r, drive_request);
      end
      HDLC_MODE_OPEN: begin
        ref_sel = st_r.od_limit_r;
        lvl_sel = scale255(st_r.od_limit_r, drive_request);
      end
      HDLC_MODE_AUDIO: begin
        ref_sel = st_r.full_ref_r;
        lvl_sel = min8(drive_request, st_r.ceiling_r);
      end
      default: begin
        ref_sel = st_r.full_ref_r;
        lvl_sel = 8'h00;
      end
    endcase
  end

  logic [7:0]  lvl_q;
  logic [7:0]  ref_q;
  logic [15:0] gain_q;
  logic [15:0] fb_q;

  // output flops; gains are 8.8 fixed point
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lvl_q  <= 8'h00;
      ref_q  <= `HDLC_RST_FULL_REF;
      gain_q <= 16'h0100;
      fb_q   <= 16'h0000;
    end else begin
      lvl_q  <= lvl_sel;
      ref_q  <= ref_sel;
      // 1 + comp/255 in 8.8
      gain_q <= 16'h0100 + 16'({8'h00, st_r.loss_comp_r} *
                16'h0100 / 16'(`HDLC_FULL_SCALE));
      // in closed loop the feedback gain scales with the stored bemf level and gain select, else zero
      fb_q   <= (mode == HDLC_MODE_CLOSED) ?
                16'(({8'h00, st_r.bemf_r} << back_emf_gain_select)) :
                16'h0000;
    end
  end

  assign drive_level    = lvl_q;
  assign full_scale_ref = ref_q;
  assign drive_gain     = gain_q;
  assign feedback_gain  = fb_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_audio_ceiling: assert property (
    @(posedge sys_clk) disable iff (reset)
    mode == HDLC_MODE_AUDIO |=> drive_level <= $past(st_r.ceiling_r))
    else $error("audio drive above ceiling");
  a_open_ref: assert property (
    @(posedge sys_clk) disable iff (reset)
    mode == HDLC_MODE_OPEN |=> full_scale_ref == $past(st_r.od_limit_r))
    else $error("open loop reference wrong");
  a_closed_ref: assert property (
    @(posedge sys_clk) disable iff (reset)
    mode == HDLC_MODE_CLOSED |=> full_scale_ref == $past(st_r.full_ref_r))
    else $error("closed loop reference wrong");
  a_od_bound: assert property (
    @(posedge sys_clk) disable iff (reset)
    mode == HDLC_MODE_CLOSED && overdrive_active
    |=> drive_level <= $past(st_r.od_limit_r))
    else $error("overdrive above limit");
  a_cal_store: assert property (
    @(posedge sys_clk) disable iff (reset)
    cal_done |=> st_r.loss_comp_r == $past(cal_loss_comp) &&
                 st_r.bemf_r == $past(cal_bemf))
    else $error("calibration result not stored");

  // host write to the limit register, then a plain read of it
  sequence s_limit_write;
    reg_wr && !cal_done && reg_addr == `HDLC_OFS_OD_LIMIT;
  endsequence
  sequence s_limit_read;
    reg_rd && !reg_wr && reg_addr == `HDLC_OFS_OD_LIMIT;
  endsequence

  a_wr_readback: assert property (
    @(posedge sys_clk) disable iff (reset)
    s_limit_write ##1 s_limit_read |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read back differs from write");
  // comp*256/255 equals comp, plus one only at full code
  a_gain_coef: assert property (
    @(posedge sys_clk) disable iff (reset)
    1'b1 |=> drive_gain == 16'h0100 + 16'($past(st_r.loss_comp_r)) +
                           16'($past(st_r.loss_comp_r) == 8'hff))
    else $error("drive gain not one plus compensation");
  a_fb_open: assert property (
    @(posedge sys_clk) disable iff (reset)
    mode != HDLC_MODE_CLOSED |=> feedback_gain == 16'h0000)
    else $error("feedback gain outside closed loop");

endmodule

// file: verification/hdlc_host.sv
/* host model: single-byte register writes and reads.
   assumes: the bench calls acc one transfer at a time. */
`timescale 1ns/1ns
module hdlc_host (
  // clock
  input  wire logic       sys_clk,
  // register access
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  // idle bus at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // one strobe cycle, then lines released to the inverse
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge sys_clk);
    reg_wr    = w;
    reg_rd    = !w;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // write, then read the same address on the very next edge
  task automatic wr_rd(input logic [7:0] a, d);
    @(negedge sys_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    @(negedge sys_clk);
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// file: verification/test_hdlc_regs.sv
/* bench of the drive level and calibration registers.
   assumes: the host model drives the register strobes. */
`timescale 1ns/1ns
`include "hdlc_defines.svh"
module test_hdlc_regs
  import hdlc_pkg::*;
;
  localparam logic [7:0] RST [5] = '{`HDLC_RST_CEILING, `HDLC_RST_FULL_REF,
    `HDLC_RST_OD_LIMIT, `HDLC_RST_LOSS_COMP, `HDLC_RST_BEMF};
  logic        sys_clk, reset, cal_done, od, dchk, wr, rd, hit;
  logic [1:0]  mode, gsel;
  logic [7:0]  rdata, lcomp, bemf, req, lvl, fsr, addr, wdata;
  logic [15:0] dg, fg;
  logic [7:0]  m [5];
  logic [8:0]  qr [$];
  logic [47:0] qd [$];
  int          error_cnt, checked;

  hdlc_host u_host (.sys_clk(sys_clk), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata));
  hdlc_regs u_dut (.sys_clk(sys_clk), .reset(reset), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_hit(hit), .cal_done(cal_done), .cal_loss_comp(lcomp),
    .cal_bemf(bemf), .drive_mode(mode), .overdrive_active(od),
    .drive_request(req), .back_emf_gain_select(gsel),
    .drive_level(lvl), .full_scale_ref(fsr), .drive_gain(dg),
    .feedback_gain(fg));

  // compare and count
  task automatic check(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // verdict
  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // read every register, noting the mirror value
  task automatic rdall;
    for (int i = 0; i < 5; i++) begin
      qr.push_back({1'b1, m[i]});
      u_host.acc(1'b0, 8'(`HDLC_OFS_CEILING + i), 8'h00);
    end
  endtask
  // one drive cycle with random request, noting all four outputs
  task automatic drv(input logic [1:0] md, input logic o);
    int l, r, g, f;
    @(negedge sys_clk);
    mode = md;
    od   = o;
    req  = 8'($urandom);
    gsel = 2'($urandom);
    r = (md == HDLC_MODE_OPEN) ? m[2] : m[1];
    l = r * req / 255;
    if (md == HDLC_MODE_AUDIO) l = (req < m[0]) ? req : m[0];
    if (o) l = (req < m[2]) ? req : m[2];
    if (md == 2'b11) l = 0;
    g = 256 + m[3] * 256 / 255;
    f = (md == HDLC_MODE_CLOSED) ? (m[4] << gsel) : 0;
    qd.push_back({l[7:0], r[7:0], g[15:0], f[15:0]});
    dchk = 1'b1;
    @(negedge sys_clk);
    dchk = 1'b0;
  endtask
  // all modes, closed loop with and without overdrive
  task automatic modes;
    repeat (3) begin
      drv(HDLC_MODE_CLOSED, 1'b0);
      drv(HDLC_MODE_CLOSED, 1'b1);
      drv(HDLC_MODE_OPEN, 1'b0);
      drv(HDLC_MODE_AUDIO, 1'b0);
      drv(2'b11, 1'b0);
    end
  endtask

  // watcher: takes the oldest note whenever a result appears
  always @(posedge sys_clk) begin : mon
    logic [47:0] n;
    logic [8:0]  q;
    if (rd === 1'b1) begin
      #1;
      q = qr.pop_front();
      check("rdata", {8'h00, rdata}, {8'h00, q[7:0]});
      check("hit", {15'h0000, hit}, {15'h0000, q[8]});
    end
    if (dchk === 1'b1) begin
      #1;
      n = qd.pop_front();
      check("level", {8'h00, lvl}, {8'h00, n[47:40]});
      check("ref", {8'h00, fsr}, {8'h00, n[39:32]});
      check("dgain", dg, n[31:16]);
      check("fgain", fg, n[15:0]);
    end
  end
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
  // main sequence
  initial begin
    reset = 1'b1;
    {cal_done, od, dchk, mode, gsel, lcomp, bemf, req} = '0;
    m = RST;
    void'($urandom(93));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    rdall();
    modes();
    for (int i = 0; i < 5; i++) begin
      m[i] = 8'($urandom);
      u_host.acc(1'b1, 8'(`HDLC_OFS_CEILING + i), m[i]);
    end
    u_host.acc(1'b1, 8'h1a, 8'h5a);
    qr.push_back({1'b0, 8'h00});
    u_host.acc(1'b0, 8'h1a, 8'h00);
    qr.push_back({1'b0, 8'h00});
    u_host.acc(1'b0, 8'h14, 8'h00);
    m[2] = 8'($urandom);
    qr.push_back({1'b1, m[2]});
    u_host.wr_rd(`HDLC_OFS_OD_LIMIT, m[2]);
    rdall();
    modes();
    lcomp = 8'($urandom);
    bemf  = 8'($urandom);
    m[3]  = lcomp;
    m[4]  = bemf;
    fork
      u_host.acc(1'b1, `HDLC_OFS_LOSS_COMP, ~lcomp);
      begin
        @(negedge sys_clk);
        cal_done = 1'b1;
        @(negedge sys_clk);
        cal_done = 1'b0;
        lcomp    = ~lcomp;
        bemf     = ~bemf;
      end
    join
    rdall();
    modes();
    // mid-run reset brings back every reset value
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    m = RST;
    rdall();
    modes();
    repeat (3) @(negedge sys_clk);
    report_and_stop();
  end
endmodule
